// ===== common/usb_gpio_pkg.sv
package usb_gpio_pkg;
   localparam int NPINS = 8;
   localparam int NSTAT = 5;
   // register byte addresses
   localparam logic [7:0] ADR_DIR  = 8'h00;
   localparam logic [7:0] ADR_DFLT = 8'h04;
   localparam logic [7:0] ADR_FUNC = 8'h08;
   localparam logic [7:0] ADR_PINS = 8'h0C;
   localparam logic [7:0] ADR_USB  = 8'h10;
   localparam logic [7:0] ADR_STAT = 8'h14;
   localparam logic [7:0] ADR_MASK = 8'h18;
   // reset values
   localparam logic [7:0] DIR_RST  = 8'h00;
   localparam logic [7:0] DFLT_RST = 8'h00;
   localparam logic [4:0] FUNC_RST = 5'h00;
   localparam logic [4:0] MASK_RST = 5'h00;
   // status bit positions
   localparam int ST_SUSP   = 0;
   localparam int ST_RESUME = 1;
   localparam int ST_CFG    = 2;
   localparam int ST_IN     = 3;
   localparam int ST_OUT    = 4;
   // pins with alternate functions
   localparam int PIN_SUSP = 0;
   localparam int PIN_CFG  = 1;
   localparam int PIN_IN   = 6;
   localparam int PIN_OUT  = 7;
   // timing
   localparam int CLK_HZ         = 25_000_000;
   localparam int IDLE_US        = 3000;
   localparam int PULSE_SHORT_MS = 100;
   localparam int PULSE_LONG_MS  = 200;
   localparam int RST_FILT_NS    = 200;
   localparam int IDLE_CYC        = (CLK_HZ / 1_000_000) * IDLE_US;
   localparam int PULSE_SHORT_CYC = (CLK_HZ / 1000) * PULSE_SHORT_MS;
   localparam int PULSE_LONG_CYC  = (CLK_HZ / 1000) * PULSE_LONG_MS;
   localparam int RST_FILT_CYC    = (RST_FILT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int PULSE_W         = 23;
   // events from the usb device core, same clock, one-cycle pulses
   typedef struct packed {
      logic busActivity;
      logic resume;
      logic busReset;
      logic configured;
      logic inMsg;
      logic outMsg;
   } usb_evt_t;
   // function enable register layout, bit 4 first
   typedef struct packed {
      logic longPulse;
      logic pulseMode;
      logic trafEn;
      logic cfgEn;
      logic suspEn;
   } func_cfg_t;
endpackage

// ===== rtl/reset_filter.sv
`timescale 1ns/1ps
// filters the external active-low reset pin into a synchronous device reset
module reset_filter #(
   parameter int FILT = usb_gpio_pkg::RST_FILT_CYC
) (
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic extRstN,
   output logic      devReset
);
   logic       rstMeta;
   logic       rstSync;
   logic [7:0] lowCnt;
   wire        lowLong = (lowCnt >= 8'(FILT - 1));

   // two-stage synchroniser on the pin
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rstMeta <= 1'b1;
         rstSync <= 1'b1;
      end else begin
         rstMeta <= extRstN;
         rstSync <= rstMeta;
      end
   end

   // a low shorter than FILT cycles never reaches the device
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         lowCnt   <= 8'h00;
         devReset <= 1'b1;
      end else if (rstSync) begin
         lowCnt   <= 8'h00;
         devReset <= 1'b0;                         // RQ13
      end else begin
         lowCnt <= lowLong ? lowCnt : lowCnt + 8'h01;
         if (lowLong)
            devReset <= 1'b1;                      // RQ14
      end
   end

   a_rst_glitch: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(devReset) |-> $past(!rstSync, 1) && $past(!rstSync, 2)) // RQ14
      else $error("device reset from a short low");
   a_rst_hold: assert property (@(posedge sys_clk) disable iff (rst)
      devReset && !rstSync |=> devReset) // RQ13
      else $error("device reset released while pin low");
endmodule

// ===== rtl/traffic_indicator.sv
`timescale 1ns/1ps
// active-low traffic indicator: timed low pulse or toggle per message
module traffic_indicator #(
   parameter int CW        = usb_gpio_pkg::PULSE_W,
   parameter int SHORT_CYC = usb_gpio_pkg::PULSE_SHORT_CYC,
   parameter int LONG_CYC  = usb_gpio_pkg::PULSE_LONG_CYC
) (
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic clr,
   input  wire logic msg,
   input  wire logic pulseMode,
   input  wire logic longPulse,
   output logic      level
);
   logic [CW-1:0] cnt;
   logic          togLvl;
   wire  [CW-1:0] loadVal = longPulse ? CW'(LONG_CYC) : CW'(SHORT_CYC);

   // a new message restarts the pulse, so bursts hold the pin low
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cnt    <= '0;
         togLvl <= 1'b1;
      end else if (clr) begin
         cnt    <= '0;
         togLvl <= 1'b1;
      end else if (msg) begin
         cnt    <= loadVal;                         // RQ18
         togLvl <= ~togLvl;
      end else if (cnt != '0) begin
         cnt <= cnt - 1'b1;
      end
   end

   assign level = pulseMode ? (cnt == '0) : togLvl; // RQ9 RQ10

   a_pulse_restart: assert property (@(posedge sys_clk) disable iff (rst || clr)
      msg |=> cnt == loadVal && !(pulseMode && level)) // RQ18
      else $error("pulse not restarted by message");
   a_toggle_flip: assert property (@(posedge sys_clk) disable iff (rst || clr)
      msg && !pulseMode ##1 !pulseMode |-> level != $past(level)) // RQ9
      else $error("toggle level did not change");
endmodule

// ===== rtl/usb_status_gpio_port.sv
// Design decisions made here: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
// Overview of operation
// RQ1: one eight-pin port, pins 0 to 7, handled together.
// RQ2: each pin is an input or output per its direction bit.
// RQ3: an output pin drives its default level until software changes it.
// RQ4: suspend indicator on pin 0 goes low in suspend, high after resume.
// RQ5: pin 0 carries the suspend indicator only when enabled.
// RQ6: configured indicator on pin 1 low after reset, high once configured.
// RQ7: configured indicator low during suspend, high again on resume.
// RQ8: pin 1 carries the configured indicator only when enabled.
// RQ9: each IN message pulses pin 6 low or toggles it, per mode.
// RQ10: each OUT message pulses pin 7 low or toggles it, per mode.
// RQ11: one enable moves pins 6 and 7 to active-low traffic use.
// RQ12: more than 3 ms without traffic to the device means suspend.
// RQ13: the device stays in reset while the reset pin is low.
// RQ14: short glitches on the reset pin are filtered out.
// RQ15: the system supplies the clock at the required accuracy.
// RQ16: suspend ends on resume, bus reset or device reset.
// RQ17: an enabled indicator forces its pin to output, overriding settings.
// RQ18: a message during a pulse restarts the pulse count.
module usb_status_gpio_port #(
   parameter int IDLE_CYCLES = usb_gpio_pkg::IDLE_CYC,
   parameter int SHORT_CYC   = usb_gpio_pkg::PULSE_SHORT_CYC,
   parameter int LONG_CYC    = usb_gpio_pkg::PULSE_LONG_CYC
) (
   input  wire logic                   sys_clk,
   input  wire logic                   rst,
   input  wire logic                   extRstN,
   input  wire usb_gpio_pkg::usb_evt_t usbEvt,
   input  wire logic [7:0]             pinIn,
   input  wire logic                   wb_cyc_i,
   input  wire logic                   wb_stb_i,
   input  wire logic                   wb_we_i,
   input  wire logic [7:0]             wb_adr_i,
   input  wire logic [3:0]             wb_sel_i,
   input  wire logic [31:0]            wb_dat_i,
   output logic [31:0]                 wb_dat_o,
   output logic                        wb_ack_o,
   output logic [7:0]                  pinOut,
   output logic [7:0]                  pinOe_n,
   output logic                        irq
);
   logic                    devReset;
   logic [7:0]              pinMeta;
   logic [7:0]              pinSync;
   logic [7:0]              dirReg;
   logic [7:0]              dfltReg;
   usb_gpio_pkg::func_cfg_t funcReg;
   logic [4:0]              statReg;
   logic [4:0]              maskReg;
   logic [16:0]             idleCnt;
   logic                    suspended;
   logic                    cfgDone;
   logic                    inLvl;
   logic                    outLvl;

   // glitch-filtered device reset from the external pin
   reset_filter u_rst (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .extRstN  (extRstN),
      .devReset (devReset)
   );

   // IN and OUT traffic indicators share mode and pulse length
   traffic_indicator #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) u_in (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .clr       (devReset),
      .msg       (usbEvt.inMsg),
      .pulseMode (funcReg.pulseMode),
      .longPulse (funcReg.longPulse),
      .level     (inLvl)
   );
   traffic_indicator #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) u_out (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .clr       (devReset),
      .msg       (usbEvt.outMsg),
      .pulseMode (funcReg.pulseMode),
      .longPulse (funcReg.longPulse),
      .level     (outLvl)
   );

   // bus decode; ack is registered, so every access takes one wait cycle
   wire access = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire wrEn   = access && wb_we_i && wb_sel_i[0];
   wire wrDir  = wrEn && (wb_adr_i == usb_gpio_pkg::ADR_DIR);
   wire wrDflt = wrEn && (wb_adr_i == usb_gpio_pkg::ADR_DFLT);
   wire wrFunc = wrEn && (wb_adr_i == usb_gpio_pkg::ADR_FUNC);
   wire wrStat = wrEn && (wb_adr_i == usb_gpio_pkg::ADR_STAT);
   wire wrMask = wrEn && (wb_adr_i == usb_gpio_pkg::ADR_MASK);

   // suspend tracking; wake has priority over a coinciding idle timeout
   wire idleDone  = (idleCnt >= 17'(IDLE_CYCLES - 1));
   wire wake      = usbEvt.resume || usbEvt.busReset;
   wire enterSusp = idleDone && !suspended && !wake && !usbEvt.busActivity;
   wire exitSusp  = suspended && wake;
   wire cfgInd    = cfgDone && !suspended;

   // hardware events that set sticky status bits
   wire [4:0] statSet = {usbEvt.outMsg, usbEvt.inMsg, usbEvt.configured, exitSusp, enterSusp};
   wire [4:0] statClr = wrStat ? wb_dat_i[4:0] : 5'h00;
   wire [4:0] next_stat = (statReg & ~statClr) | statSet;

   // per-pin function select: indicator pins override direction and default
   wire [7:0] fnOn = {funcReg.trafEn, funcReg.trafEn, 4'h0, funcReg.cfgEn, funcReg.suspEn}; // RQ11 RQ5 RQ8
   wire [7:0] fnLvl = {outLvl, inLvl, 4'h0, cfgInd, !suspended};     // RQ4 RQ7
   wire [7:0] next_pinOut = (fnOn & fnLvl) | (~fnOn & dfltReg);        // RQ3 RQ17
   wire [7:0] next_pinOe_n = devReset ? 8'hFF : ~(fnOn | dirReg);      // RQ1 RQ2 RQ17

   // read mux; unmapped addresses read as zero
   wire [7:0] rdByte =
      (wb_adr_i == usb_gpio_pkg::ADR_DIR)  ? dirReg :
      (wb_adr_i == usb_gpio_pkg::ADR_DFLT) ? dfltReg :
      (wb_adr_i == usb_gpio_pkg::ADR_FUNC) ? {3'h0, funcReg} :
      (wb_adr_i == usb_gpio_pkg::ADR_PINS) ? pinSync :
      (wb_adr_i == usb_gpio_pkg::ADR_USB)  ? {6'h00, cfgDone, suspended} :
      (wb_adr_i == usb_gpio_pkg::ADR_STAT) ? {3'h0, statReg} :
      (wb_adr_i == usb_gpio_pkg::ADR_MASK) ? {3'h0, maskReg} : 8'h00;

   // pin inputs come from outside the clock domain
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pinMeta <= 8'h00;
         pinSync <= 8'h00;
      end else begin
         pinMeta <= pinIn;
         pinSync <= pinMeta;
      end
   end

   // wishbone answer
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= access;
         wb_dat_o <= access ? {24'h00_0000, rdByte} : 32'h0000_0000;
      end
   end

   // software registers survive a device reset so the port comes back as set
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         dirReg  <= usb_gpio_pkg::DIR_RST;
         dfltReg <= usb_gpio_pkg::DFLT_RST;
         funcReg <= usb_gpio_pkg::FUNC_RST;
         maskReg <= usb_gpio_pkg::MASK_RST;
      end else begin
         if (wrDir)
            dirReg <= wb_dat_i[7:0];
         if (wrDflt)
            dfltReg <= wb_dat_i[7:0];
         if (wrFunc)
            funcReg <= wb_dat_i[4:0];
         if (wrMask)
            maskReg <= wb_dat_i[4:0];
      end
   end

   // status and interrupt; a set in the clearing cycle wins
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         statReg <= 5'h00;
         irq     <= 1'b0;
      end else begin
         statReg <= next_stat;
         irq     <= |(next_stat & maskReg);
      end
   end

   // idle timer, suspend and configured state
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         idleCnt   <= 17'h0_0000;
         suspended <= 1'b0;
         cfgDone   <= 1'b0;
      end else if (devReset) begin
         idleCnt   <= 17'h0_0000;
         suspended <= 1'b0;                        // RQ16
         cfgDone   <= 1'b0;                        // RQ6
      end else begin
         if (usbEvt.busActivity || suspended || wake)
            idleCnt <= 17'h0_0000;
         else if (!idleDone)
            idleCnt <= idleCnt + 17'h0_0001;
         if (exitSusp)
            suspended <= 1'b0;                     // RQ16
         else if (enterSusp)
            suspended <= 1'b1;                     // RQ12
         if (usbEvt.busReset)
            cfgDone <= 1'b0;
         else if (usbEvt.configured)
            cfgDone <= 1'b1;                       // RQ6
      end
   end

   // pins come straight from flip-flops
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pinOut  <= 8'h00;
         pinOe_n <= 8'hFF;
      end else begin
         pinOut  <= next_pinOut;
         pinOe_n <= next_pinOe_n;
      end
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst || devReset);

   a_plain_dir: assert property (##1 pinOe_n[5:2] == ~$past(dirReg[5:2])) // RQ2
      else $error("plain pin direction wrong");
   a_plain_level: assert property (##1 pinOut[5:2] == $past(dfltReg[5:2])) // RQ3
      else $error("plain pin level wrong");
   a_susp_pin: assert property (funcReg.suspEn && suspended |=> !pinOut[0] && !pinOe_n[0]) // RQ4
      else $error("suspend pin not low in suspend");
   a_susp_off: assert property (!funcReg.suspEn |=> pinOe_n[0] == !$past(dirReg[0])) // RQ5
      else $error("pin 0 not plain when disabled");
   a_cfg_pin: assert property (funcReg.cfgEn |=> pinOut[1] == $past(cfgDone && !suspended)) // RQ7
      else $error("configured pin wrong");
   a_cfg_plain: assert property (!funcReg.cfgEn |=> pinOut[1] == $past(dfltReg[1])) // RQ8
      else $error("pin 1 not plain when disabled");
   a_traffic_drive: assert property (funcReg.trafEn |=> pinOe_n[7:6] == 2'b00) // RQ11
      else $error("traffic pins not driven");
   a_in_pulse: assert property (funcReg.trafEn && funcReg.pulseMode && usbEvt.inMsg
      ##1 funcReg.trafEn |=> !pinOut[6]) // RQ9
      else $error("in pulse missing");
   a_out_pulse: assert property (funcReg.trafEn && funcReg.pulseMode && usbEvt.outMsg
      ##1 funcReg.trafEn |=> !pinOut[7]) // RQ10
      else $error("out pulse missing");
   a_idle_suspend: assert property (enterSusp |=> suspended ##1 !pinOe_n[0] || !funcReg.suspEn) // RQ12
      else $error("idle timeout did not suspend");
   a_wake_exit: assert property (suspended && wake |=> !suspended) // RQ16
      else $error("suspend not left on wake");

   // the device reset leaves neither suspend nor a stale configuration behind
   a_cfg_reset: assert property ($fell(devReset) |-> !cfgDone && !suspended) // RQ6
      else $error("configured state kept over device reset");
   // with traffic use off, pins 6 and 7 follow their direction bits
   a_traffic_plain: assert property (!funcReg.trafEn |=> pinOe_n[7:6] == ~$past(dirReg[7:6])) // RQ11
      else $error("pins 6 and 7 not plain when disabled");
   // awake with the suspend function on, pin 0 is driven high
   a_susp_awake: assert property (funcReg.suspEn && !suspended |=> pinOut[0] && !pinOe_n[0]) // RQ4
      else $error("suspend pin not high while awake");
endmodule

// ===== tb/host_pin_model.sv
`timescale 1ns/1ps
// usb core event source and application circuitry standing on the pins
module host_pin_model (
   input  wire logic              sys_clk,
   input  wire logic              hostActive,
   input  wire logic [5:0]        evtReq,
   input  wire logic [7:0]        extDrive,
   input  wire logic [7:0]        pinOut,
   input  wire logic [7:0]        pinOe_n,
   output usb_gpio_pkg::usb_evt_t usbEvt,
   output logic [7:0]             pinIn
);
   logic [3:0] tick = 4'h0;
   // host frames every 16 cycles keep the idle timer from expiring
   always_ff @(posedge sys_clk) begin
      tick <= tick + 4'h1;
   end
   // bench requests ride on top of the periodic bus activity
   assign usbEvt = evtReq | {hostActive && tick == 4'h0, 5'h00};
   // a driven pin reads back its own level, a released one the application drive
   assign pinIn = (~pinOe_n & pinOut) | (pinOe_n & extDrive);
endmodule

// ===== tb/usb_status_gpio_port_tb_top.sv
`timescale 1ns/1ps
// self-checking bench for the status gpio port
module usb_status_gpio_port_tb_top;
   typedef struct packed {
      logic       we;
      logic [7:0] adr;
      logic [7:0] wd;
      logic [7:0] rexp;
   } row_t;
   localparam int IDLE = 50;
   logic                   sys_clk, rst, extRstN, hostActive;
   logic                   wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq;
   logic [5:0]             evtReq;
   logic [7:0]             extDrive, pinIn, pinOut, pinOe_n, wb_adr_i;
   logic [31:0]            wb_dat_i, wb_dat_o, rd;
   usb_gpio_pkg::usb_evt_t usbEvt;
   int                     errTotal, nTests, n;
   // reset values first, then write and read back the direction, default, mask and function registers
   row_t rows [12] = '{'{0, usb_gpio_pkg::ADR_DIR, 0, 0}, '{0, usb_gpio_pkg::ADR_DFLT, 0, 0},
      '{0, usb_gpio_pkg::ADR_FUNC, 0, 0}, '{0, usb_gpio_pkg::ADR_MASK, 0, 0}, '{0, usb_gpio_pkg::ADR_STAT, 0, 0},
      '{0, usb_gpio_pkg::ADR_USB, 0, 0}, '{1, usb_gpio_pkg::ADR_DIR, 8'h0F, 8'h0F},
      '{1, usb_gpio_pkg::ADR_DFLT, 8'hA5, 8'hA5}, '{1, usb_gpio_pkg::ADR_MASK, 8'hFF, 8'h1F},
      '{1, usb_gpio_pkg::ADR_MASK, 8'h00, 8'h00}, '{1, usb_gpio_pkg::ADR_FUNC, 8'h3F, 8'h1F},
      '{1, usb_gpio_pkg::ADR_FUNC, 8'h00, 8'h00}};

   usb_status_gpio_port #(.IDLE_CYCLES(IDLE), .SHORT_CYC(20), .LONG_CYC(40)) u_usb_status_gpio_port (
      .sys_clk(sys_clk), .rst(rst), .extRstN(extRstN), .usbEvt(usbEvt), .pinIn(pinIn),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'h1),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pinOut(pinOut), .pinOe_n(pinOe_n),
      .irq(irq));
   host_pin_model u_host_pin_model (
      .sys_clk(sys_clk), .hostActive(hostActive), .evtReq(evtReq), .extDrive(extDrive),
      .pinOut(pinOut), .pinOe_n(pinOe_n), .usbEvt(usbEvt), .pinIn(pinIn));

   // 25 mhz clock from the surrounding system
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   // watchdog, a hang still reaches the verdict
   initial begin
      repeat (20000) @(posedge sys_clk);
      errTotal++;
      complete_run();
   end

   task automatic complete_run();
      if (errTotal == 0 && nTests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      nTests++;
      if (seen !== exp) begin
         errTotal++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // classic cycle: request held until ack is sampled high, released right after
   task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] wd);
      int k;
      @(posedge sys_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= {24'h0, wd};
      for (k = 0; k < 20 && wb_ack_o !== 1'b1; k++) @(posedge sys_clk);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (k == 20) begin
         errTotal++;
         complete_run();
      end
   endtask
   task automatic rdchk(input string what, input logic [7:0] adr, input logic [7:0] exp);
      wb(1'b0, adr, 8'h00);
      check(what, rd, {24'h0, exp});
   endtask
   // one-cycle event pulse, returns once the pin flop has had time to follow
   task automatic evt(input logic [5:0] b);
      @(posedge sys_clk);
      evtReq <= b;
      @(posedge sys_clk);
      evtReq <= 6'h00;
      repeat (2) @(posedge sys_clk);
      #1;
   endtask
   task automatic settle();
      repeat (3) @(posedge sys_clk);
      #1;
   endtask
   // bounded wait for a pin level, n gives the cycles it took
   task automatic wait_pin(input int b, input logic lvl);
      for (n = 0; n < 60 && pinOut[b] !== lvl; n++) begin
         @(posedge sys_clk);
         #1;
      end
      if (n == 60) begin
         errTotal++;
         complete_run();
      end
   endtask

   initial begin
      rst = 1'b1;
      extRstN = 1'b1;
      hostActive = 1'b1;
      evtReq = 6'h00;
      extDrive = 8'h3C;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 8'h00;
      wb_dat_i = 32'h0;
      repeat (8) @(posedge sys_clk);
      check("pins in reset", {pinOe_n, pinOut, 7'h0, irq}, 24'hFF0000);
      rst <= 1'b0;
      foreach (rows[i]) begin
         if (rows[i].we) wb(1'b1, rows[i].adr, rows[i].wd);
         rdchk("register", rows[i].adr, rows[i].rexp);
      end
      wb(1'b1, 8'h20, 8'hFF);
      rdchk("unmapped", 8'h20, 8'h00);
      settle();
      check("oe", pinOe_n, 8'hF0);
      check("default", pinOut & 8'h0F, 8'h05);
      rdchk("pins", usb_gpio_pkg::ADR_PINS, 8'h35);
      // suspend and configured indicators override an all-input direction
      wb(1'b1, usb_gpio_pkg::ADR_DIR, 8'h00);
      wb(1'b1, usb_gpio_pkg::ADR_FUNC, 8'h03);
      settle();
      check("cfg low", {pinOe_n[1:0], pinOut[1:0]}, 4'b0001);
      evt(6'h04);
      check("cfg high", pinOut[1:0], 2'b11);
      @(posedge sys_clk);
      hostActive <= 1'b0;
      evt(6'h20);
      repeat (IDLE - 10) @(posedge sys_clk);
      #1;
      check("still awake", pinOut[0], 1'b1);
      wait_pin(0, 1'b0);
      check("suspended", pinOut[1:0], 2'b00);
      evt(6'h10);
      check("resumed", pinOut[1:0], 2'b11);
      rdchk("status", usb_gpio_pkg::ADR_STAT, 8'h07);
      check("irq masked", irq, 1'b0);
      wb(1'b1, usb_gpio_pkg::ADR_MASK, 8'h04);
      settle();
      check("irq set", irq, 1'b1);
      wb(1'b1, usb_gpio_pkg::ADR_STAT, 8'h04);
      settle();
      check("irq clear", irq, 1'b0);
      // bus reset leaves suspend and drops configuration
      wait_pin(0, 1'b0);
      evt(6'h08);
      check("bus reset", pinOut[1:0], 2'b01);
      hostActive <= 1'b1;
      // pulse mode: a second message restarts the short pulse
      wb(1'b1, usb_gpio_pkg::ADR_FUNC, 8'h0C);
      settle();
      check("traffic on", {pinOe_n[7:6], pinOut[7:6]}, 4'b0011);
      evt(6'h02);
      check("in pulse", pinOut[7:6], 2'b10);
      repeat (8) @(posedge sys_clk);
      evt(6'h02);
      repeat (14) @(posedge sys_clk);
      #1;
      check("restart", pinOut[6], 1'b0);
      wait_pin(6, 1'b1);
      check("short end", n <= 10, 1'b1);
      wb(1'b1, usb_gpio_pkg::ADR_FUNC, 8'h1C);
      evt(6'h01);
      repeat (30) @(posedge sys_clk);
      #1;
      check("long pulse", pinOut[7:6], 2'b01);
      wait_pin(7, 1'b1);
      check("long end", n <= 14, 1'b1);
      // toggle mode flips the level per message; the toggle flop also
      // followed the three pulse-mode messages, so out starts low, in high
      wb(1'b1, usb_gpio_pkg::ADR_FUNC, 8'h04);
      evt(6'h01);
      check("toggle out", pinOut[7:6], 2'b11);
      evt(6'h01);
      evt(6'h02);
      check("toggle in", pinOut[7:6], 2'b00);
      rdchk("msg status", usb_gpio_pkg::ADR_STAT & 8'hFF, 8'h1B);
      // a short low on the reset pin is ignored, a long one resets the device
      evt(6'h04);
      @(posedge sys_clk);
      extRstN <= 1'b0;
      repeat (3) @(posedge sys_clk);
      extRstN <= 1'b1;
      repeat (10) @(posedge sys_clk);
      rdchk("glitch", usb_gpio_pkg::ADR_USB, 8'h02);
      extRstN <= 1'b0;
      repeat (12) @(posedge sys_clk);
      #1;
      check("dev reset", pinOe_n, 8'hFF);
      @(posedge sys_clk);
      extRstN <= 1'b1;
      repeat (6) @(posedge sys_clk);
      rdchk("usb cleared", usb_gpio_pkg::ADR_USB, 8'h00);
      rdchk("func kept", usb_gpio_pkg::ADR_FUNC, 8'h04);
      complete_run();
   end
endmodule
